// file: logic/gpc_pkg.sv
// Shared constants and types of the general purpose pin controller.
package gpc_pkg;

  // ==========================================================================
  // Sizes
  localparam int NPINS = 22;
  localparam int SD_NUM = 6;
  localparam int SD_FIRST_PIN = 10;
  localparam int MAP_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRAP_W = 4;
  localparam int STRAP_FIRST_PIN = 18;
  localparam int SLV_CLK_PIN = 14;
  localparam int SLV_DATA_PIN = 15;
  localparam int NFUNC = 3;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_OUT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_SET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OUT_CLR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_OE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ALT0 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ALT1 = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STICKY = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENA = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ACT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_MAP_BASE = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STRAP = 8'h40;
  localparam logic [ADDR_W-1:0] MAP_STRIDE = 8'h04;

  // ==========================================================================
  // Reset values and pin groups
  localparam logic [NPINS-1:0] PINS_ZERO = 22'h000000;
  localparam logic [SD_NUM*MAP_W-1:0] MAP_RST = 30'h00000000;
  localparam logic [STRAP_W-1:0] SLAVE_STRAP_DEF = 4'h5;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;
  // Pins whose function two or three is a multiplexed two-wire clock.
  localparam logic [NPINS-1:0] TWC_ALT2_MASK = 22'h0effc0;
  localparam logic [NPINS-1:0] TWC_ALT3_MASK = 22'h300010;

  // ==========================================================================
  // Pin function codes
  typedef enum logic [1:0] {
    GPC_FUNC_NORMAL = 2'h0,
    GPC_FUNC_ALT1 = 2'h1,
    GPC_FUNC_ALT2 = 2'h2,
    GPC_FUNC_ALT3 = 2'h3
  } gpc_func_t;

  // All software visible state of the controller.
  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] alt0;
    logic [NPINS-1:0] alt1;
    logic [NPINS-1:0] sticky;
    logic [NPINS-1:0] ena;
    logic [SD_NUM*MAP_W-1:0] map;
    logic [STRAP_W-1:0] strap;
    logic [DATA_W-1:0] rdata;
  } gpc_state_t;

endpackage : gpc_pkg

// file: logic/gpc_sync_change.sv
// Two stage pin synchroniser with a change detector behind it.
`timescale 1ns/1ns
`default_nettype none
module gpc_sync_change #(
  parameter int W = 22
) (
  input wire logic clk_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] change_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } gpc_sync_state_t;

  gpc_sync_state_t st_ff;
  gpc_sync_state_t nxt_st;

  // =========================================================================
  // Pipeline
  // No reset here on purpose: the pipe keeps sampling while reset is held,
  // so levels are valid at release and straps can be caught during reset.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // Only the second and third stages are looked at.
  assign level_o = st_ff.s2;
  assign change_o = st_ff.s2 ^ st_ff.s3;

endmodule : gpc_sync_change
`default_nettype wire

// file: logic/gpc_top.sv
// General purpose pin controller: direction, output, overlay, change flags, detects.
`timescale 1ns/1ns
`default_nettype none
module gpc_top #(
  parameter int NPINS = gpc_pkg::NPINS,
  parameter logic [gpc_pkg::STRAP_W-1:0] SLAVE_STRAP = gpc_pkg::SLAVE_STRAP_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic [gpc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [gpc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [gpc_pkg::DATA_W-1:0] rdata_o,
  input wire logic [gpc_pkg::NPINS-1:0] pin_i,
  output logic [gpc_pkg::NPINS-1:0] pin_o,
  output logic [gpc_pkg::NPINS-1:0] pin_oe_o,
  input wire logic [gpc_pkg::NFUNC*gpc_pkg::NPINS-1:0] alt_data_i,
  input wire logic [gpc_pkg::NFUNC*gpc_pkg::NPINS-1:0] alt_oe_i,
  output logic [gpc_pkg::NPINS-1:0] pin_level_o,
  output logic [2*gpc_pkg::NPINS-1:0] pin_func_o,
  input wire logic twc_clk_low_i,
  output logic twc_clk_fb_o,
  output logic slave_mode_o,
  output logic slave_mgmt_clock_o,
  output logic slave_mgmt_data_o,
  input wire logic slave_mgmt_data_i,
  input wire logic slave_mgmt_data_oe_i,
  output logic [gpc_pkg::STRAP_W-1:0] boot_strap_cfg_o,
  output logic [gpc_pkg::SD_NUM-1:0] parallel_detect_en_o,
  output logic [gpc_pkg::SD_NUM-1:0] parallel_detect_in_o,
  output logic [gpc_pkg::SD_NUM*gpc_pkg::MAP_W-1:0] detect_port_index_o,
  output logic irq_o
);

  localparam int N = gpc_pkg::NPINS;
  localparam int MW = gpc_pkg::MAP_W;

  gpc_pkg::gpc_state_t st_ff;
  gpc_pkg::gpc_state_t nxt_st;
  logic [N-1:0] level;
  logic [N-1:0] change;
  logic [N-1:0] twc_on;
  logic slave_mode;

  // =========================================================================
  // Pin synchronisation and change detection
  gpc_sync_change #(
    .W(N)
  ) u_sync (
    .clk_i(clk_i),
    .async_i(pin_i),
    .level_o(level),
    .change_o(change)
  );

  // Slave mode is decided by the straps caught at reset, never by software.
  assign slave_mode = (st_ff.strap == SLAVE_STRAP);

  // =========================================================================
  // Register file next state
  // The overlay bits sit outside the soft reset so a reset of the control
  // block never reroutes pins that boards depend on.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = gpc_pkg::RD_ZERO;
    if (wr_i) begin
      case (addr_i)
        gpc_pkg::OFS_OUT: begin
          nxt_st.out = wdata_i[N-1:0];
        end
        gpc_pkg::OFS_OUT_SET: begin
          nxt_st.out = st_ff.out | wdata_i[N-1:0];
        end
        gpc_pkg::OFS_OUT_CLR: begin
          nxt_st.out = st_ff.out & ~wdata_i[N-1:0];
        end
        gpc_pkg::OFS_OE: begin
          nxt_st.oe = wdata_i[N-1:0];
        end
        gpc_pkg::OFS_ALT0: begin
          nxt_st.alt0 = wdata_i[N-1:0];
        end
        gpc_pkg::OFS_ALT1: begin
          nxt_st.alt1 = wdata_i[N-1:0];
        end
        gpc_pkg::OFS_STICKY: begin
          nxt_st.sticky = st_ff.sticky & ~wdata_i[N-1:0];
        end
        gpc_pkg::OFS_IRQ_ENA: begin
          nxt_st.ena = wdata_i[N-1:0];
        end
        default: begin
          for (int i = 0; i < gpc_pkg::SD_NUM; i++) begin
            if (addr_i == gpc_pkg::OFS_MAP_BASE + 8'(i) * gpc_pkg::MAP_STRIDE) begin
              nxt_st.map[i*MW +: MW] = wdata_i[MW-1:0];
            end
          end
        end
      endcase
    end
    // A change in the same cycle as a clear still lands in the flag.
    nxt_st.sticky = nxt_st.sticky | change;
    if (rd_i) begin
      case (addr_i)
        gpc_pkg::OFS_OUT: begin
          nxt_st.rdata[N-1:0] = st_ff.out;
        end
        gpc_pkg::OFS_IN: begin
          nxt_st.rdata[N-1:0] = level;
        end
        gpc_pkg::OFS_OE: begin
          nxt_st.rdata[N-1:0] = st_ff.oe;
        end
        gpc_pkg::OFS_ALT0: begin
          nxt_st.rdata[N-1:0] = st_ff.alt0;
        end
        gpc_pkg::OFS_ALT1: begin
          nxt_st.rdata[N-1:0] = st_ff.alt1;
        end
        gpc_pkg::OFS_STICKY: begin
          nxt_st.rdata[N-1:0] = st_ff.sticky;
        end
        gpc_pkg::OFS_IRQ_ENA: begin
          nxt_st.rdata[N-1:0] = st_ff.ena;
        end
        gpc_pkg::OFS_IRQ_ACT: begin
          nxt_st.rdata[N-1:0] = st_ff.sticky & st_ff.ena;
        end
        gpc_pkg::OFS_STRAP: begin
          nxt_st.rdata[gpc_pkg::STRAP_W-1:0] = st_ff.strap;
        end
        default: begin
          for (int i = 0; i < gpc_pkg::SD_NUM; i++) begin
            if (addr_i == gpc_pkg::OFS_MAP_BASE + 8'(i) * gpc_pkg::MAP_STRIDE) begin
              nxt_st.rdata[MW-1:0] = st_ff.map[i*MW +: MW];
            end
          end
        end
      endcase
    end
    // Soft reset clears everything but the overlay, the straps and the read data.
    if (soft_rst_i) begin
      nxt_st.out = gpc_pkg::PINS_ZERO;
      nxt_st.oe = gpc_pkg::PINS_ZERO;
      nxt_st.sticky = gpc_pkg::PINS_ZERO;
      nxt_st.ena = gpc_pkg::PINS_ZERO;
      nxt_st.map = gpc_pkg::MAP_RST;
    end
    // Device reset clears all and keeps catching the straps while held.
    if (!rst_n_i) begin
      nxt_st.out = gpc_pkg::PINS_ZERO;
      nxt_st.oe = gpc_pkg::PINS_ZERO;
      nxt_st.alt0 = gpc_pkg::PINS_ZERO;
      nxt_st.alt1 = gpc_pkg::PINS_ZERO;
      nxt_st.sticky = gpc_pkg::PINS_ZERO;
      nxt_st.ena = gpc_pkg::PINS_ZERO;
      nxt_st.map = gpc_pkg::MAP_RST;
      nxt_st.strap = level[gpc_pkg::STRAP_FIRST_PIN +: gpc_pkg::STRAP_W];
      nxt_st.rdata = gpc_pkg::RD_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // =========================================================================
  // Per pin function routing
  // The strap pins carry no special logic after release, so they act as
  // ordinary pins once the strap value has been caught.
  generate
    for (genvar n = 0; n < N; n++) begin : g_pin
      gpc_pkg::gpc_func_t code;
      logic is_twc;
      logic is_sd;
      assign code = gpc_pkg::gpc_func_t'({st_ff.alt1[n], st_ff.alt0[n]});
      assign is_twc = (code == gpc_pkg::GPC_FUNC_ALT2 && gpc_pkg::TWC_ALT2_MASK[n]) ||
                      (code == gpc_pkg::GPC_FUNC_ALT3 && gpc_pkg::TWC_ALT3_MASK[n]);
      assign is_sd = (code == gpc_pkg::GPC_FUNC_ALT3) && (n >= gpc_pkg::SD_FIRST_PIN) &&
                     (n < gpc_pkg::SD_FIRST_PIN + gpc_pkg::SD_NUM);
      // A disabled two-wire clock neither drives nor feeds back.
      assign twc_on[n] = is_twc && st_ff.out[n];
      assign pin_func_o[2*n +: 2] = code;
      always_comb begin
        pin_o[n] = 1'b0;
        pin_oe_o[n] = 1'b0;
        if (slave_mode && n == gpc_pkg::SLV_CLK_PIN) begin
          pin_oe_o[n] = 1'b0;
        end else if (slave_mode && n == gpc_pkg::SLV_DATA_PIN) begin
          pin_o[n] = slave_mgmt_data_i;
          pin_oe_o[n] = slave_mgmt_data_oe_i;
        end else if (code == gpc_pkg::GPC_FUNC_NORMAL) begin
          pin_o[n] = st_ff.out[n];
          pin_oe_o[n] = st_ff.oe[n];
        end else if (is_twc) begin
          // Open drain: only the low phase of the clock is driven.
          pin_oe_o[n] = twc_clk_low_i && st_ff.out[n];
        end else if (is_sd) begin
          pin_oe_o[n] = 1'b0;
        end else begin
          pin_o[n] = alt_data_i[(int'(code) - 1) * N + n];
          pin_oe_o[n] = alt_oe_i[(int'(code) - 1) * N + n];
        end
      end
    end
  endgenerate

  // =========================================================================
  // Parallel signal detects
  generate
    for (genvar i = 0; i < gpc_pkg::SD_NUM; i++) begin : g_sd
      assign parallel_detect_en_o[i] = g_pin[gpc_pkg::SD_FIRST_PIN + i].is_sd;
      assign parallel_detect_in_o[i] = level[gpc_pkg::SD_FIRST_PIN + i];
    end
  endgenerate
  assign detect_port_index_o = st_ff.map;

  // =========================================================================
  // Remaining outputs
  // Feedback sees a stretched clock on any enabled line pulled low.
  assign twc_clk_fb_o = &(level | ~twc_on);
  assign slave_mode_o = slave_mode;
  assign slave_mgmt_clock_o = level[gpc_pkg::SLV_CLK_PIN] & slave_mode;
  assign slave_mgmt_data_o = level[gpc_pkg::SLV_DATA_PIN] & slave_mode;
  assign boot_strap_cfg_o = st_ff.strap;
  assign pin_level_o = level;
  assign rdata_o = st_ff.rdata;
  assign irq_o = |(st_ff.sticky & st_ff.ena);

  // =========================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_oe_after_reset: assert property ($rose(rst_n_i) |-> st_ff.oe == gpc_pkg::PINS_ZERO)
    else $error("drive enables not clear after reset");
  a_in_read_level: assert property (rd_i && addr_i == gpc_pkg::OFS_IN
    |=> rdata_o[N-1:0] == $past(level))
    else $error("input register does not show pin levels");
  a_out_drive_pin: assert property (st_ff.alt0[0] == 1'b0 && st_ff.alt1[0] == 1'b0
    && st_ff.oe[0] |-> pin_oe_o[0] && pin_o[0] == st_ff.out[0])
    else $error("normal pin does not drive output value");
  a_set_atomic: assert property (wr_i && addr_i == gpc_pkg::OFS_OUT_SET && !soft_rst_i
    |=> st_ff.out == ($past(st_ff.out) | $past(wdata_i[N-1:0])))
    else $error("set write disturbed other bits");
  a_clr_atomic: assert property (wr_i && addr_i == gpc_pkg::OFS_OUT_CLR && !soft_rst_i
    |=> st_ff.out == ($past(st_ff.out) & ~$past(wdata_i[N-1:0])))
    else $error("clear write disturbed other bits");
  a_alt_soft_keep: assert property (soft_rst_i && !wr_i |=> $stable(st_ff.alt0)
    && $stable(st_ff.alt1))
    else $error("soft reset changed the overlay");
  a_func_select: assert property (st_ff.alt1[5] == 1'b0 && st_ff.alt0[5]
    |-> pin_o[5] == alt_data_i[5] && pin_oe_o[5] == alt_oe_i[5])
    else $error("function one not routed");
  a_func_three: assert property (st_ff.alt1[5] && st_ff.alt0[5]
    |-> pin_o[5] == alt_data_i[2*N + 5])
    else $error("function three not routed");
  a_slave_take: assert property (slave_mode |-> !pin_oe_o[gpc_pkg::SLV_CLK_PIN]
    && pin_oe_o[gpc_pkg::SLV_DATA_PIN] == slave_mgmt_data_oe_i)
    else $error("slave pins not taken over");
  a_strap_hold: assert property (rst_n_i |=> $stable(st_ff.strap))
    else $error("strap value moved after reset");
  a_sticky_set: assert property ((change != gpc_pkg::PINS_ZERO) && !soft_rst_i
    |=> (st_ff.sticky & $past(change)) == $past(change))
    else $error("input change not recorded");
  a_irq_masked: assert property (st_ff.ena == gpc_pkg::PINS_ZERO |-> !irq_o)
    else $error("interrupt raised while masked");
  a_ident_read: assert property (rd_i && addr_i == gpc_pkg::OFS_IRQ_ACT
    |=> rdata_o[N-1:0] == ($past(st_ff.sticky) & $past(st_ff.ena)))
    else $error("active sources not sticky and enable");
  a_sd_input: assert property (parallel_detect_en_o[0] |-> !pin_oe_o[gpc_pkg::SD_FIRST_PIN]
    && parallel_detect_in_o[0] == level[gpc_pkg::SD_FIRST_PIN])
    else $error("detect pin driven or not forwarded");
  a_twc_gate: assert property (g_pin[6].is_twc && !st_ff.out[6] |-> !pin_oe_o[6])
    else $error("disabled two-wire clock driven");

  c_set_write: cover property (wr_i && addr_i == gpc_pkg::OFS_OUT_SET ##1 rd_i);
  c_irq_raise: cover property (!irq_o ##1 irq_o);
  c_sd_enable: cover property (parallel_detect_en_o != 6'h00);
  c_twc_enable: cover property (twc_on != gpc_pkg::PINS_ZERO);

endmodule : gpc_top
`default_nettype wire

// file: verification/gpc_board_model.sv
// Board side model: resolves every pin from the controller drive and the board levels.
`timescale 1ns/1ns
`default_nettype none
module gpc_board_model (
  input wire logic [gpc_pkg::NPINS-1:0] drive_i,
  input wire logic [gpc_pkg::NPINS-1:0] drive_en_i,
  input wire logic [gpc_pkg::NPINS-1:0] board_level_i,
  output logic [gpc_pkg::NPINS-1:0] pin_level_o
);
  // ==========================================================================
  // Pin resolution
  // A driven pin shows the drive, an undriven one the board level; contention is not modelled.
  assign pin_level_o = (drive_en_i & drive_i) | (~drive_en_i & board_level_i);
endmodule : gpc_board_model
`default_nettype wire

// file: verification/test_general_purpose_io_controller.sv
// Self-checking testbench of the general purpose pin controller.
`timescale 1ns/1ns
`default_nettype none
module test_general_purpose_io_controller;
  typedef struct packed {logic op; logic [7:0] addr; logic [31:0] data;} gpc_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic soft_rst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [21:0] pin_i, pin_o, pin_oe_o, pin_level_o, board = 22'h280000;
  logic [65:0] alt_data_i = '0;
  logic [65:0] alt_oe_i = '0;
  logic [43:0] pin_func_o, exp_func;
  logic twc_clk_low_i = 1'b0;
  logic twc_clk_fb_o, slave_mode_o, slave_mgmt_clock_o, slave_mgmt_data_o, irq_o;
  logic slave_mgmt_data_i = 1'b0;
  logic slave_mgmt_data_oe_i = 1'b0;
  logic [3:0] boot_strap_cfg_o;
  logic [5:0] parallel_detect_en_o, parallel_detect_in_o;
  logic [29:0] detect_port_index_o, exp_map;
  int fail_count = 0;
  int checks = 0;
  gpc_row_t rows [14] = '{
    '{1'b1, 8'h10, 32'h0}, '{1'b1, 8'h00, 32'h0}, '{1'b1, 8'h14, 32'h0},
    '{1'b0, 8'h00, 32'h0f0f0f}, '{1'b1, 8'h00, 32'h0f0f0f},
    '{1'b0, 8'h04, 32'h300000}, '{1'b1, 8'h00, 32'h3f0f0f},
    '{1'b0, 8'h08, 32'h00000f}, '{1'b1, 8'h00, 32'h3f0f00},
    '{1'b1, 8'h04, 32'h0}, '{1'b0, 8'h3c, 32'hffffffff}, '{1'b1, 8'h3c, 32'h1f},
    '{1'b0, 8'h20, 32'hffffffff}, '{1'b1, 8'h20, 32'h3fffff}};

  gpc_top gpc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .soft_rst_i(soft_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .alt_data_i(alt_data_i),
    .alt_oe_i(alt_oe_i), .pin_level_o(pin_level_o), .pin_func_o(pin_func_o),
    .twc_clk_low_i(twc_clk_low_i), .twc_clk_fb_o(twc_clk_fb_o), .slave_mode_o(slave_mode_o),
    .slave_mgmt_clock_o(slave_mgmt_clock_o), .slave_mgmt_data_o(slave_mgmt_data_o),
    .slave_mgmt_data_i(slave_mgmt_data_i), .slave_mgmt_data_oe_i(slave_mgmt_data_oe_i),
    .boot_strap_cfg_o(boot_strap_cfg_o), .parallel_detect_en_o(parallel_detect_en_o),
    .parallel_detect_in_o(parallel_detect_in_o), .detect_port_index_o(detect_port_index_o),
    .irq_o(irq_o));

  gpc_board_model gpc_board_model_i (.drive_i(pin_o), .drive_en_i(pin_oe_o),
    .board_level_i(board), .pin_level_o(pin_i));

  // ==========================================================================
  // Clock and helpers
  // Free running 20 MHz clock.
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bus cycles end one step past the taking edge so outputs have settled.
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : rd

  // Straps are only meaningful while reset is held, so they are set first.
  task dev_reset(input logic [3:0] strap);
    @(posedge clk_i);
    board[21:18] <= strap;
    rst_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
  endtask : dev_reset

  task board_set(input logic [21:0] v);
    @(posedge clk_i);
    board <= v;
    repeat (6) @(posedge clk_i);
    #1;
  endtask : board_set

  task summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // ==========================================================================
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #(50 * 5000);
    fail_count++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    dev_reset(4'ha);
    chk(boot_strap_cfg_o, 4'ha);
    chk(slave_mode_o, 1'b0);
    chk(pin_oe_o, 22'h0);
    foreach (rows[i]) begin
      if (rows[i].op) rd(rows[i].addr, rows[i].data);
      else wr(rows[i].addr, rows[i].data);
    end
    $display("test register rows done");
    // Direction, drive and loop back through the board.
    wr(8'h10, 32'h0000ff);
    chk(pin_oe_o, 22'h0000ff);
    chk(pin_o[7:0], 8'h00);
    board_set(22'h2800aa);
    rd(8'h0c, 32'h2800aa & 32'h3fff00);
    $display("test direction done");
    // Change flags, masking and the active source view.
    wr(8'h20, 32'h000004);
    wr(8'h1c, 32'h3fffff);
    rd(8'h1c, 32'h0);
    board_set(22'h2900aa);
    rd(8'h1c, 32'h010000);
    chk(irq_o, 1'b0);
    rd(8'h24, 32'h0);
    wr(8'h20, 32'h010004);
    chk(irq_o, 1'b1);
    rd(8'h24, 32'h010000);
    wr(8'h1c, 32'h010000);
    chk(irq_o, 1'b0);
    $display("test change flags done");
    // Each alternate function code, 1 to 3, on pin 5 hands the pin to that function.
    for (int k = 1; k <= 3; k++) begin
      @(posedge clk_i);
      alt_oe_i <= 66'h1 << ((k - 1) * 22 + 5);
      alt_data_i <= 66'h1 << ((k - 1) * 22 + 5);
      wr(8'h14, (k & 1) ? 32'h20 : 32'h0);
      wr(8'h18, (k & 2) ? 32'h20 : 32'h0);
      chk(pin_func_o[11:10], k[1:0]);
      chk({pin_oe_o[5], pin_o[5]}, 2'h3);
    end
    $display("test function codes done");
    // Detect map first, then the detect function on pins 10 to 15.
    exp_func = '0;
    for (int i = 0; i < 6; i++) begin
      exp_map[5*i+:5] = 5'(i + 1);
      exp_func[2*(10+i)+:2] = 2'h3;
      wr(8'h28 + 8'(4 * i), 32'(i + 1));
    end
    @(posedge clk_i);
    alt_oe_i <= '1;
    wr(8'h10, 32'h00fc00);
    wr(8'h14, 32'h00fc00);
    wr(8'h18, 32'h00fc00);
    board_set(22'h28b400);
    chk(pin_func_o, exp_func);
    chk(detect_port_index_o, exp_map);
    chk(parallel_detect_en_o, 6'h3f);
    chk(parallel_detect_in_o, 6'h2d);
    chk(pin_oe_o[15:10], 6'h00);
    $display("test parallel detect done");
    // A soft reset keeps the overlay but clears the other control state.
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    alt_oe_i <= '0;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    rd(8'h14, 32'h00fc00);
    rd(8'h18, 32'h00fc00);
    rd(8'h10, 32'h0);
    rd(8'h28, 32'h0);
    $display("test soft reset done");
    // Muxed two-wire clock on pin 6, gated by its output bit; the board pulls the line up.
    board_set(22'h28b440);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h000040);
    wr(8'h04, 32'h000040);
    chk(twc_clk_fb_o, 1'b1);
    @(posedge clk_i);
    twc_clk_low_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk({pin_oe_o[6], pin_o[6]}, 2'h2);
    chk(twc_clk_fb_o, 1'b0);
    wr(8'h08, 32'h000040);
    chk(pin_oe_o[6], 1'b0);
    chk(twc_clk_fb_o, 1'b1);
    @(posedge clk_i);
    twc_clk_low_i <= 1'b0;
    $display("test two-wire clock done");
    // Device reset with the slave strap: overlay cleared, slave pins taken over.
    dev_reset(4'h5);
    @(posedge clk_i);
    slave_mgmt_data_i <= 1'b1;
    slave_mgmt_data_oe_i <= 1'b1;
    wr(8'h14, 32'h00c000);
    chk(boot_strap_cfg_o, 4'h5);
    chk(slave_mode_o, 1'b1);
    chk({pin_oe_o[15:14], pin_o[15]}, 3'h5);
    board_set(22'h144000);
    chk(slave_mgmt_clock_o, 1'b1);
    chk(slave_mgmt_data_o, 1'b1);
    chk(pin_level_o, 22'h14c000);
    rd(8'h18, 32'h0);
    rd(8'h0c, 32'h14c000);
    // Read data stands for one cycle only, then falls back to zero.
    @(posedge clk_i);
    #1;
    chk(rdata_o, 32'h0);
    chk(boot_strap_cfg_o, 4'h5);
    $display("test strap and slave done");
    summarize();
  end
endmodule : test_general_purpose_io_controller
`default_nettype wire
